// >>> hw/link_status_slot_control_regs.sv
// The Avalon-MM slave port was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "link_slot_defs.svh"
module link_status_slot_control_regs #(
    parameter int ADDR_W = 8
) (
    input  wire logic              sys_clk_i,
    input  wire logic              rstn_i,
    input  wire logic [ADDR_W-1:0] avs_address_i,
    input  wire logic              avs_read_i,
    input  wire logic              avs_write_i,
    input  wire logic [31:0]       avs_writedata_i,
    input  wire logic [3:0]        avs_byteenable_i,
    output var  logic [31:0]       avs_readdata_o,
    output var  logic              avs_waitrequest_o,
    input  wire logic [3:0]        link_speed_i,
    input  wire logic [5:0]        link_width_i,
    input  wire logic              link_training_i,
    input  wire logic              dl_active_i,
    input  wire logic              slot_clock_strap_i,
    input  wire logic              independent_clock_i,
    input  wire logic              attn_button_present_i,
    input  wire logic              hotplug_capable_i,
    input  wire logic              attn_ind_present_i,
    input  wire logic              pwr_ind_present_i,
    input  wire logic              dll_report_capable_i,
    input  wire logic              attn_button_pressed_i,
    input  wire logic              presence_detect_i,
    output var  logic [1:0]        attn_ind_o,
    output var  logic [1:0]        pwr_ind_o,
    output var  logic              notify_attn_o,
    output var  logic              notify_presence_o,
    output var  logic              notify_link_o,
    output var  logic              notify_o
);

    if (ADDR_W < 8) begin : g_addr_check
        $error("ADDR_W must be at least 8 to reach the slot control word");
    end

    // Bus phase
    link_slot_pkg::bus_phase_e phase;
    link_slot_pkg::bus_phase_e next_phase;
    logic                      next_waitrequest;
    logic [31:0]               next_readdata;

    // Decode
    logic [5:0]                word_idx;
    logic                      req;
    logic                      commit;
    logic                      hit_link;
    logic                      hit_slot;
    logic                      we_lo;
    logic                      we_hi;

    // Slot clock capture
    logic                      slot_clk;
    logic                      captured;
    logic                      next_slot_clk;
    logic                      next_captured;

    // Control fields
    logic                      attn_en;
    logic                      pres_en;
    logic                      dll_en;
    link_slot_pkg::ind_code_t  attn_ind;
    link_slot_pkg::ind_code_t  pwr_ind;

    // Notifications
    logic                      ev_attn;
    logic                      ev_pres;
    logic                      ev_link;
    logic                      next_notify;
    logic                      next_notify_attn;
    logic                      next_notify_pres;
    logic                      next_notify_link;

    // Indicator pin next values
    link_slot_pkg::ind_code_t  next_attn_pin;
    link_slot_pkg::ind_code_t  next_pwr_pin;

    // Register images
    link_slot_pkg::reg16_t     link_image;
    link_slot_pkg::reg16_t     slot_image;

    // Unmapped words read zero and drop writes
    assign word_idx = avs_address_i[7:2];
    assign req      = avs_read_i || avs_write_i;
    // Write takes effect on the edge where waitrequest is low
    assign commit   = avs_write_i && (phase == link_slot_pkg::BUS_ACK);
    assign hit_link = (word_idx == `LSS_IDX_LINK_STATE);
    assign hit_slot = (word_idx == `LSS_IDX_SLOT_CTRL);
    // Lane 0 holds bits 7:0, lane 1 bits 15:8
    assign we_lo    = commit && hit_slot && avs_byteenable_i[0];
    assign we_hi    = commit && hit_slot && avs_byteenable_i[1];

    // Bus handshake: one wait cycle, then a single ack cycle
    always_comb begin
        next_phase       = link_slot_pkg::BUS_WAIT;
        next_waitrequest = 1'b1;
        next_readdata    = avs_readdata_o;
        unique case (phase)
            link_slot_pkg::BUS_WAIT: begin
                if (req) begin
                    next_phase       = link_slot_pkg::BUS_ACK;
                    next_waitrequest = 1'b0;
                    next_readdata    = 32'h0000_0000;
                    if (avs_read_i && hit_link) begin
                        next_readdata = {16'h0000, link_image};
                    end else if (avs_read_i && hit_slot) begin
                        next_readdata = {16'h0000, slot_image};
                    end
                end
            end
            link_slot_pkg::BUS_ACK: begin
                // A request still high here waits one more cycle
                next_phase       = link_slot_pkg::BUS_WAIT;
                next_waitrequest = 1'b1;
            end
        endcase
    end

    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            phase             <= link_slot_pkg::BUS_WAIT;
            avs_waitrequest_o <= 1'b1;
            avs_readdata_o    <= 32'h0000_0000;
        end else begin
            phase             <= next_phase;
            avs_waitrequest_o <= next_waitrequest;
            avs_readdata_o    <= next_readdata;
        end
    end

    // Strap taken once after reset release, never under reset itself
    always_comb begin
        next_slot_clk = slot_clk;
        next_captured = captured;
        if (!captured) begin
            next_slot_clk = slot_clock_strap_i && !independent_clock_i;
            next_captured = 1'b1;
        end
    end

    // One bit serves every function, so all report alike
    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            slot_clk <= 1'b0;
            captured <= 1'b0;
        end else begin
            slot_clk <= next_slot_clk;
            captured <= next_captured;
        end
    end

    // Link state report image
    always_comb begin
        link_image                     = 16'h0000;
        link_image[3:0]                = link_speed_i;
        link_image[9:4]                = link_width_i;
        link_image[`LSS_BIT_TRAINING]  = link_training_i;
        link_image[`LSS_BIT_SLOT_CLK]  = slot_clk;
        link_image[`LSS_BIT_DL_ACTIVE] = dl_active_i;
    end

    // Slot control image; bits outside this set read zero
    always_comb begin
        slot_image                        = 16'h0000;
        slot_image[`LSS_BIT_ATTN_EN]      = attn_en;
        slot_image[`LSS_BIT_PRES_EN]      = pres_en;
        slot_image[`LSS_LSB_ATTN_IND+:2]  = attn_ind;
        slot_image[`LSS_LSB_PWR_IND+:2]   = pwr_ind;
        slot_image[`LSS_BIT_DLL_EN]       = dll_en;
    end

    slot_ctrl_field #(
        .WIDTH (1),
        .RESET (`LSS_EN_RESET)
    ) u_attn_en (
        .sys_clk_i (sys_clk_i),
        .rstn_i    (rstn_i),
        .present_i (attn_button_present_i),
        .we_i      (we_lo),
        .wdata_i   (avs_writedata_i[`LSS_BIT_ATTN_EN]),
        .q_o       (attn_en)
    );

    slot_ctrl_field #(
        .WIDTH (1),
        .RESET (`LSS_EN_RESET)
    ) u_pres_en (
        .sys_clk_i (sys_clk_i),
        .rstn_i    (rstn_i),
        .present_i (hotplug_capable_i),
        .we_i      (we_lo),
        .wdata_i   (avs_writedata_i[`LSS_BIT_PRES_EN]),
        .q_o       (pres_en)
    );

    // Fields reset to Off, a defined code; the pins reset to 0 and show Off one clock after release
    slot_ctrl_field #(
        .WIDTH (2),
        .RESET (`LSS_IND_OFF)
    ) u_attn_ind (
        .sys_clk_i (sys_clk_i),
        .rstn_i    (rstn_i),
        .present_i (attn_ind_present_i),
        .we_i      (we_lo),
        .wdata_i   (avs_writedata_i[`LSS_LSB_ATTN_IND+:2]),
        .q_o       (attn_ind)
    );

    slot_ctrl_field #(
        .WIDTH (2),
        .RESET (`LSS_IND_OFF)
    ) u_pwr_ind (
        .sys_clk_i (sys_clk_i),
        .rstn_i    (rstn_i),
        .present_i (pwr_ind_present_i),
        .we_i      (we_hi),
        .wdata_i   (avs_writedata_i[`LSS_LSB_PWR_IND+:2]),
        .q_o       (pwr_ind)
    );

    slot_ctrl_field #(
        .WIDTH (1),
        .RESET (`LSS_EN_RESET)
    ) u_dll_en (
        .sys_clk_i (sys_clk_i),
        .rstn_i    (rstn_i),
        .present_i (dll_report_capable_i),
        .we_i      (we_hi),
        .wdata_i   (avs_writedata_i[`LSS_BIT_DLL_EN]),
        .q_o       (dll_en)
    );

    // Indicator pins copy the control fields one clock later
    always_comb begin
        next_attn_pin = attn_ind;
        next_pwr_pin  = pwr_ind;
    end

    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            attn_ind_o <= 2'h0;
            pwr_ind_o  <= 2'h0;
        end else begin
            attn_ind_o <= next_attn_pin;
            pwr_ind_o  <= next_pwr_pin;
        end
    end

    // Detectors start low, but enables reset off, so a level high at release is not counted
    slot_event_notify #(
        .LEVEL_CHANGE (1'b0)
    ) u_ev_attn (
        .sys_clk_i (sys_clk_i),
        .rstn_i    (rstn_i),
        .event_i   (attn_button_pressed_i),
        .enable_i  (attn_en),
        .notify_o  (ev_attn)
    );

    slot_event_notify #(
        .LEVEL_CHANGE (1'b1)
    ) u_ev_pres (
        .sys_clk_i (sys_clk_i),
        .rstn_i    (rstn_i),
        .event_i   (presence_detect_i),
        .enable_i  (pres_en),
        .notify_o  (ev_pres)
    );

    slot_event_notify #(
        .LEVEL_CHANGE (1'b1)
    ) u_ev_link (
        .sys_clk_i (sys_clk_i),
        .rstn_i    (rstn_i),
        .event_i   (dl_active_i),
        .enable_i  (dll_en),
        .notify_o  (ev_link)
    );

    // Pulses are not held; software must catch them downstream
    always_comb begin
        next_notify_attn = ev_attn;
        next_notify_pres = ev_pres;
        next_notify_link = ev_link;
        next_notify      = ev_attn || ev_pres || ev_link;
    end

    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            notify_attn_o     <= 1'b0;
            notify_presence_o <= 1'b0;
            notify_link_o     <= 1'b0;
            notify_o          <= 1'b0;
        end else begin
            notify_attn_o     <= next_notify_attn;
            notify_presence_o <= next_notify_pres;
            notify_link_o     <= next_notify_link;
            notify_o          <= next_notify;
        end
    end

endmodule
`default_nettype wire

// >>> hw/link_slot_defs.svh
`ifndef LINK_SLOT_DEFS_SVH
`define LINK_SLOT_DEFS_SVH
`define LSS_IDX_LINK_STATE 6'h12
`define LSS_IDX_SLOT_CTRL  6'h18
`define LSS_BIT_SLOT_CLK   12
`define LSS_BIT_DL_ACTIVE  13
`define LSS_BIT_TRAINING   11
`define LSS_BIT_ATTN_EN    0
`define LSS_BIT_PRES_EN    3
`define LSS_LSB_ATTN_IND   6
`define LSS_LSB_PWR_IND    8
`define LSS_BIT_DLL_EN     12
`define LSS_EN_RESET       1'h0
`define LSS_IND_OFF        2'h3
`endif

// >>> hw/link_slot_pkg.sv
package link_slot_pkg;
    typedef logic [1:0]  ind_code_t;
    typedef logic [15:0] reg16_t;
    typedef enum logic {
        BUS_WAIT,
        BUS_ACK
    } bus_phase_e;
endpackage

// >>> hw/slot_ctrl_field.sv
`timescale 1ns/1ps
`default_nettype none
module slot_ctrl_field #(
    parameter int                 WIDTH = 1,
    parameter logic [WIDTH-1:0]   RESET = '0
) (
    input  wire logic             sys_clk_i,
    input  wire logic             rstn_i,
    input  wire logic             present_i,
    input  wire logic             we_i,
    input  wire logic [WIDTH-1:0] wdata_i,
    output var  logic [WIDTH-1:0] q_o
);
    logic [WIDTH-1:0] next_q;
    always_comb begin
        next_q = q_o;
        if (!present_i) begin
            // Absent feature: read-only zero
            next_q = '0;
        end else if (we_i) begin
            next_q = wdata_i;
        end
    end
    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            q_o <= RESET;
        end else begin
            q_o <= next_q;
        end
    end
endmodule
`default_nettype wire

// >>> hw/slot_event_notify.sv
`timescale 1ns/1ps
`default_nettype none
module slot_event_notify #(
    parameter bit LEVEL_CHANGE = 1'b0
) (
    input  wire logic sys_clk_i,
    input  wire logic rstn_i,
    input  wire logic event_i,
    input  wire logic enable_i,
    output var  logic notify_o
);
    logic last;
    logic seen;
    logic next_notify;
    // Level inputs notify on either edge; pulse inputs on each high cycle
    assign seen = LEVEL_CHANGE ? (event_i != last) : event_i;
    always_comb begin
        next_notify = seen && enable_i;
    end
    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            last     <= 1'b0;
            notify_o <= 1'b0;
        end else begin
            last     <= event_i;
            notify_o <= next_notify;
        end
    end
endmodule
`default_nettype wire

// >>> bench/link_regs_props.sv
`timescale 1ns/1ps
`default_nettype none
module link_regs_props #(parameter int ADDR_W = 8) (
    input wire logic              sys_clk_i,
    input wire logic              rstn_i,
    input wire logic [ADDR_W-1:0] avs_address_i,
    input wire logic              avs_read_i,
    input wire logic              avs_write_i,
    input wire logic [31:0]       avs_writedata_i,
    input wire logic [3:0]        avs_byteenable_i,
    input wire logic              avs_waitrequest_o,
    input wire logic              attn_ind_present_i,
    input wire logic              pwr_ind_present_i,
    input wire logic              attn_button_pressed_i,
    input wire logic              presence_detect_i,
    input wire logic              dl_active_i,
    input wire logic [1:0]        attn_ind_o,
    input wire logic [1:0]        pwr_ind_o,
    input wire logic              notify_attn_o,
    input wire logic              notify_presence_o,
    input wire logic              notify_link_o,
    input wire logic              notify_o
);
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!rstn_i);
    sequence s_wr_ack;
        avs_write_i && !avs_waitrequest_o && avs_address_i == 8'h60;
    endsequence
    property p_ack_one;
        (avs_read_i || avs_write_i) && avs_waitrequest_o |=> !avs_waitrequest_o;
    endproperty
    property p_ack_single;
        !avs_waitrequest_o |=> avs_waitrequest_o;
    endproperty
    property p_notify_sum;
        notify_attn_o || notify_presence_o || notify_link_o |-> notify_o;
    endproperty
    property p_attn_cause;
        notify_attn_o |-> $past(attn_button_pressed_i, 2);
    endproperty
    property p_pres_cause;
        notify_presence_o |-> $past(presence_detect_i, 2) != $past(presence_detect_i, 3);
    endproperty
    property p_link_cause;
        notify_link_o |-> $past(dl_active_i, 2) != $past(dl_active_i, 3);
    endproperty
    property p_attn_absent;
        !attn_ind_present_i [*3] |-> attn_ind_o == 2'h0;
    endproperty
    property p_pwr_absent;
        !pwr_ind_present_i [*3] |-> pwr_ind_o == 2'h0;
    endproperty
    property p_attn_follow;
        s_wr_ack ##0 (avs_byteenable_i[0] && attn_ind_present_i) ##1 attn_ind_present_i
            |=> attn_ind_o == $past(avs_writedata_i[7:6], 2);
    endproperty
    property p_pwr_follow;
        s_wr_ack ##0 (avs_byteenable_i[1] && pwr_ind_present_i) ##1 pwr_ind_present_i
            |=> pwr_ind_o == $past(avs_writedata_i[9:8], 2);
    endproperty
    a_ack_one: assert property (p_ack_one) else $error("no ack after request");
    a_ack_single: assert property (p_ack_single) else $error("ack longer than one cycle");
    a_notify_sum: assert property (p_notify_sum) else $error("summary notify missing");
    a_attn_cause: assert property (p_attn_cause) else $error("button notify uncaused");
    a_pres_cause: assert property (p_pres_cause) else $error("presence notify uncaused");
    a_link_cause: assert property (p_link_cause) else $error("link notify uncaused");
    a_attn_absent: assert property (p_attn_absent) else $error("absent indicator driven");
    a_pwr_absent: assert property (p_pwr_absent) else $error("absent power driven");
    a_attn_follow: assert property (p_attn_follow) else $error("attention not written");
    a_pwr_follow: assert property (p_pwr_follow) else $error("power not written");
endmodule
bind link_status_slot_control_regs link_regs_props #(.ADDR_W(ADDR_W)) props (.*);
`default_nettype wire

// >>> bench/link_status_slot_control_regs_tb.sv
`timescale 1ns/1ps
`default_nettype none
module link_status_slot_control_regs_tb;
    logic        sys_clk_i, rstn_i, avs_read_i, avs_write_i, avs_waitrequest_o;
    logic [7:0]  avs_address_i;
    logic [31:0] avs_writedata_i, avs_readdata_o;
    logic [3:0]  avs_byteenable_i, link_speed_i;
    logic [5:0]  link_width_i;
    logic        link_training_i, dl_active_i, slot_clock_strap_i, independent_clock_i;
    logic        attn_button_present_i, hotplug_capable_i, attn_ind_present_i;
    logic        pwr_ind_present_i, dll_report_capable_i;
    logic        attn_button_pressed_i, presence_detect_i;
    logic [1:0]  attn_ind_o, pwr_ind_o;
    logic        notify_attn_o, notify_presence_o, notify_link_o, notify_o;
    int          failures = 0;
    int          tests_run = 0;
    link_status_slot_control_regs uut (.*);
    initial begin
        sys_clk_i = 1'b0;
        forever #5 sys_clk_i = ~sys_clk_i;
    end
    task automatic finish_test;
        if (failures == 0 && tests_run > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        tests_run++;
        if (g !== e) begin
            failures++;
            $display("wrong value at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    task automatic bus(input logic w, input logic [7:0] a, input logic [15:0] d,
                       input logic [3:0] be, output logic [31:0] rd);
        @(posedge sys_clk_i);
        avs_read_i <= !w;
        avs_write_i <= w;
        avs_address_i <= a;
        avs_writedata_i <= {16'h0000, d};
        avs_byteenable_i <= be;
        do @(posedge sys_clk_i); while (avs_waitrequest_o !== 1'b0);
        rd = avs_readdata_o;
        avs_read_i <= 1'b0;
        avs_write_i <= 1'b0;
    endtask
    task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] r;
        bus(1'b0, a, 16'h0000, 4'h3, r);
        chk(r, e);
    endtask
    task automatic wr(input logic [7:0] a, input logic [15:0] d, input logic [3:0] be);
        logic [31:0] r;
        bus(1'b1, a, d, be, r);
    endtask
    task automatic ev(input logic [2:0] e, input logic [2:0] x);
        @(posedge sys_clk_i);
        attn_button_pressed_i <= e[0];
        presence_detect_i <= presence_detect_i ^ e[1];
        dl_active_i <= dl_active_i ^ e[2];
        @(posedge sys_clk_i);
        attn_button_pressed_i <= 1'b0;
        @(posedge sys_clk_i);
        #1 chk({notify_link_o, notify_presence_o, notify_attn_o}, x);
        chk(notify_o, {2'h0, |x});
        @(posedge sys_clk_i);
        #1 chk({notify_o, notify_link_o, notify_presence_o, notify_attn_o}, 4'h0);
    endtask
    task automatic caps(input logic v);
        @(posedge sys_clk_i);
        {attn_button_present_i, hotplug_capable_i, attn_ind_present_i} <= {3{v}};
        {pwr_ind_present_i, dll_report_capable_i} <= {2{v}};
        repeat (2) @(posedge sys_clk_i);
    endtask
    task automatic do_reset;
        rstn_i <= 1'b0;
        repeat (20) @(posedge sys_clk_i);
        rstn_i <= 1'b1;
        repeat (2) @(posedge sys_clk_i);
    endtask
    task automatic t_reset;
        rdchk(8'h48, 32'h0000_3041);
        rdchk(8'h60, 32'h0000_03C0);
        chk({pwr_ind_o, attn_ind_o}, 32'h0000_000F);
    endtask
    task automatic t_ind;
        wr(8'h60, 16'h0100, 4'h3);
        wr(8'h60, 16'h0240, 4'h1);
        @(posedge sys_clk_i);
        #1 chk({pwr_ind_o, attn_ind_o}, 32'h0000_0005);
        rdchk(8'h60, 32'h0000_0140);
    endtask
    task automatic t_notify;
        wr(8'h60, 16'h1009, 4'h3);
        ev(3'h7, 3'h7);
        ev(3'h1, 3'h1);
        rdchk(8'h48, 32'h0000_1041);
        ev(3'h4, 3'h4);
        wr(8'h60, 16'h0000, 4'h3);
        ev(3'h7, 3'h0);
    endtask
    task automatic t_absent;
        caps(1'b0);
        wr(8'h60, 16'hFFFF, 4'hF);
        rdchk(8'h60, 32'h0000_0000);
        chk({pwr_ind_o, attn_ind_o}, 32'h0000_0000);
        ev(3'h7, 3'h0);
        caps(1'b1);
        wr(8'h04, 16'hFFFF, 4'h3);
        rdchk(8'h04, 32'h0000_0000);
        wr(8'h48, 16'hFFFF, 4'h3);
        rdchk(8'h48, 32'h0000_3041);
    endtask
    task automatic t_indep;
        independent_clock_i <= 1'b1;
        do_reset;
        rdchk(8'h48, 32'h0000_2041);
    endtask
    initial begin
        {rstn_i, avs_read_i, avs_write_i, avs_address_i, avs_writedata_i} = '0;
        {avs_byteenable_i, link_training_i, independent_clock_i} = '0;
        {attn_button_pressed_i, presence_detect_i} = '0;
        link_speed_i = 4'h1;
        link_width_i = 6'h04;
        {dl_active_i, slot_clock_strap_i} = 2'h3;
        {attn_button_present_i, hotplug_capable_i, attn_ind_present_i} = 3'h7;
        {pwr_ind_present_i, dll_report_capable_i} = 2'h3;
        do_reset;
        t_reset;
        t_ind;
        t_notify;
        t_absent;
        t_indep;
        finish_test;
    end
    initial begin
        #100000;
        failures++;
        finish_test;
    end
endmodule
`default_nettype wire
